// >>> dsof_consts.svh
// register offsets, reset values and option codes of the drive status flag block
// assumed: included by the package and the design, nothing else
`ifndef DSOF_CONSTS_SVH
`define DSOF_CONSTS_SVH
`define DSOF_ADDR_W        8
`define DSOF_OFF_OVH_LVL   8'h00
`define DSOF_OFF_LOWCUR_LVL 8'h04
`define DSOF_OFF_PROG_OUT  8'h08
`define DSOF_OFF_SEL_T11   8'h0c
`define DSOF_OFF_SEL_T12   8'h10
`define DSOF_OFF_SEL_RLY   8'h14
`define DSOF_OFF_CFG       8'h18
`define DSOF_OFF_FLAGS     8'h1c
`define DSOF_OFF_IRQ_STAT  8'h20
`define DSOF_OFF_IRQ_MASK  8'h24
`define DSOF_RST_OVH_LVL   16'hffff
`define DSOF_RST_LOWCUR_LVL 16'h0000
`define DSOF_RST_SEL_T11   8'h2d
`define DSOF_RST_SEL_T12   8'h32
`define DSOF_RST_SEL_RLY   8'h33
`define DSOF_CODE_W        8
`define DSOF_CODE_LOWCUR   8'h2b
`define DSOF_CODE_PROG1    8'h2c
`define DSOF_CODE_45       8'h2d
`define DSOF_CODE_PROG3    8'h2e
`define DSOF_CODE_READY    8'h32
`define DSOF_CODE_FWD      8'h33
`define DSOF_CODE_REV      8'h34
`define DSOF_CFG_CODE45_PROG2 0
`define DSOF_IRQ_OVH       0
`define DSOF_IRQ_LOWCUR    1
`define DSOF_IRQ_RDY_FALL  2
`define DSOF_IRQ_REJECT    3
`endif

// >>> dsof_pkg.sv
// types of the drive status flag block
// assumed: compiled before the design module
`include "dsof_consts.svh"
package dsof_pkg;
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] current;
  } dsof_meas_t;
  typedef struct packed {
    logic running;
    logic reverse;
    logic can_accept;
  } dsof_state_t;
  typedef struct packed {
    logic       reverse_running_flag;
    logic       forward_running_flag;
    logic       drive_ready_flag;
    logic [2:0] program_output;
    logic       low_current_indication;
    logic       heatsink_overheat_warning;
  } dsof_flags_t;
  typedef struct packed {
    logic t11;
    logic t12;
    logic relay;
  } dsof_term_t;
endpackage

// >>> dsof_top.sv
// drive status flags, option code selection and output terminal drive
// assumed: measurements and drive state come from logic on sys_clk
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dsof_consts.svh"

//
// Contract
// - overheat warning while temperature exceeds level
// - low current while current below threshold
// - three program outputs set only by software
// - ready flag follows ability to accept commands
// - commands acted on only while ready
// - forward flag only while driving forward
// - reverse flag only while driving reverse
// - any flag routable to 11, 12, relay
module dsof_top
  import dsof_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [`DSOF_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output var  logic [31:0]            rdata,
  input  wire dsof_meas_t             meas,
  input  wire dsof_state_t            drive,
  input  wire logic                   op_cmd,
  output var  logic                   op_cmd_go,
  output var  dsof_term_t             term,
  output var  dsof_flags_t            flags,
  output var  logic                   irq
);

  logic [15:0] ovh_lvl_q;
  logic [15:0] lowcur_lvl_q;
  logic [2:0]  prog_q;
  logic [7:0]  sel_t11_q;
  logic [7:0]  sel_t12_q;
  logic [7:0]  sel_rly_q;
  logic        cfg_q;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;
  logic [3:0]  ev;
  logic [31:0] rdata_d;
  dsof_flags_t flags_d;
  logic        wr_ovh;
  logic        wr_lowcur;
  logic        wr_prog;
  logic        wr_t11;
  logic        wr_t12;
  logic        wr_rly;
  logic        wr_cfg;
  logic        wr_stat;
  logic        wr_mask;
  logic        t11_d;
  logic        t12_d;
  logic        rly_d;

  // one decoder per terminal; all read the same unregistered flags, so terminals never disagree
  dsof_opt_mux #(
    .CODE_W (`DSOF_CODE_W)
  ) u_mux_t11 (
    .code      (sel_t11_q),
    .f         (flags_d),
    .c45_prog2 (cfg_q),
    .sel       (t11_d)
  );

  dsof_opt_mux #(
    .CODE_W (`DSOF_CODE_W)
  ) u_mux_t12 (
    .code      (sel_t12_q),
    .f         (flags_d),
    .c45_prog2 (cfg_q),
    .sel       (t12_d)
  );

  dsof_opt_mux #(
    .CODE_W (`DSOF_CODE_W)
  ) u_mux_rly (
    .code      (sel_rly_q),
    .f         (flags_d),
    .c45_prog2 (cfg_q),
    .sel       (rly_d)
  );

  assign wr_ovh  = wr_stb && (addr == `DSOF_OFF_OVH_LVL);
  assign wr_lowcur = wr_stb && (addr == `DSOF_OFF_LOWCUR_LVL);
  assign wr_prog = wr_stb && (addr == `DSOF_OFF_PROG_OUT);
  assign wr_t11  = wr_stb && (addr == `DSOF_OFF_SEL_T11);
  assign wr_t12  = wr_stb && (addr == `DSOF_OFF_SEL_T12);
  assign wr_rly  = wr_stb && (addr == `DSOF_OFF_SEL_RLY);
  assign wr_cfg  = wr_stb && (addr == `DSOF_OFF_CFG);
  assign wr_stat = wr_stb && (addr == `DSOF_OFF_IRQ_STAT);
  assign wr_mask = wr_stb && (addr == `DSOF_OFF_IRQ_MASK);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovh_lvl_q <= `DSOF_RST_OVH_LVL;
      lowcur_lvl_q <= `DSOF_RST_LOWCUR_LVL;
    end else begin
      if (wr_ovh) begin
        ovh_lvl_q <= wdata[15:0];
      end
      if (wr_lowcur) begin
        lowcur_lvl_q <= wdata[15:0];
      end
    end
  end

  // program outputs move only on a software write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_q <= 3'h0;
    end else if (wr_prog) begin
      prog_q <= wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_t11_q <= `DSOF_RST_SEL_T11;
      sel_t12_q <= `DSOF_RST_SEL_T12;
      sel_rly_q <= `DSOF_RST_SEL_RLY;
      cfg_q     <= 1'b0;
    end else begin
      if (wr_t11) begin
        sel_t11_q <= wdata[7:0];
      end
      if (wr_t12) begin
        sel_t12_q <= wdata[7:0];
      end
      if (wr_rly) begin
        sel_rly_q <= wdata[7:0];
      end
      if (wr_cfg) begin
        cfg_q <= wdata[`DSOF_CFG_CODE45_PROG2];
      end
    end
  end

  // flags come straight from this cycle's measurements and state
  always_comb begin
    flags_d                           = '0;
    flags_d.heatsink_overheat_warning = meas.temp > ovh_lvl_q;
    flags_d.low_current_indication    = meas.current < lowcur_lvl_q;
    flags_d.program_output            = prog_q;
    flags_d.drive_ready_flag          = drive.can_accept;
    flags_d.forward_running_flag      = drive.running && !drive.reverse;
    flags_d.reverse_running_flag      = drive.running && drive.reverse;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= flags_d;
    end
  end

  // one cycle from flag cause to terminal; mux reads the unregistered flags for that
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      term <= '0;
    end else begin
      term.t11   <= t11_d;
      term.t12   <= t12_d;
      term.relay <= rly_d;
    end
  end

  // the gate uses the flag the commander sees, so both agree on readiness
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_cmd_go <= 1'b0;
    end else begin
      op_cmd_go <= op_cmd && flags.drive_ready_flag;
    end
  end

  assign ev[`DSOF_IRQ_OVH]      = flags_d.heatsink_overheat_warning && !flags.heatsink_overheat_warning;
  assign ev[`DSOF_IRQ_LOWCUR]   = flags_d.low_current_indication && !flags.low_current_indication;
  assign ev[`DSOF_IRQ_RDY_FALL] = !flags_d.drive_ready_flag && flags.drive_ready_flag;
  assign ev[`DSOF_IRQ_REJECT]   = op_cmd && !flags.drive_ready_flag;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wdata[3:0] : 4'h0)) | ev;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= 4'h0;
    end else if (wr_mask) begin
      mask_q <= wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    case (addr)
      `DSOF_OFF_OVH_LVL:  rdata_d = {16'h0, ovh_lvl_q};
      `DSOF_OFF_LOWCUR_LVL: rdata_d = {16'h0, lowcur_lvl_q};
      `DSOF_OFF_PROG_OUT: rdata_d = {29'h0, prog_q};
      `DSOF_OFF_SEL_T11:  rdata_d = {24'h0, sel_t11_q};
      `DSOF_OFF_SEL_T12:  rdata_d = {24'h0, sel_t12_q};
      `DSOF_OFF_SEL_RLY:  rdata_d = {24'h0, sel_rly_q};
      `DSOF_OFF_CFG:      rdata_d = {31'h0, cfg_q};
      `DSOF_OFF_FLAGS:    rdata_d = {24'h0, flags};
      `DSOF_OFF_IRQ_STAT: rdata_d = {28'h0, stat_q};
      `DSOF_OFF_IRQ_MASK: rdata_d = {28'h0, mask_q};
      default:            rdata_d = 32'h0;
    endcase
  end

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd_stb ? rdata_d : 32'h0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ovh_warning: assert property (
    ##1 flags.heatsink_overheat_warning == ($past(meas.temp) > $past(ovh_lvl_q)))
    else $error("overheat warning does not follow temperature");

  a_low_current: assert property (
    ##1 flags.low_current_indication == ($past(meas.current) < $past(lowcur_lvl_q)))
    else $error("low current does not follow output current");

  a_prog_sw_only: assert property (
    !$stable(flags.program_output) |-> $past(wr_prog, 2))
    else $error("program output changed without a write");

  a_ready_flag: assert property (
    $rose(drive.can_accept) |=> flags.drive_ready_flag ##0 $rose(flags.drive_ready_flag))
    else $error("ready flag not following drive");

  a_cmd_gated: assert property (
    op_cmd_go |-> $past(op_cmd) && $past(flags.drive_ready_flag))
    else $error("command acted on while not ready");

  a_fwd_flag: assert property (
    (drive.running && !drive.reverse) |=> flags.forward_running_flag && !flags.reverse_running_flag)
    else $error("forward flag wrong during forward drive");

  a_rev_flag: assert property (
    (drive.running && drive.reverse) |=> flags.reverse_running_flag && !flags.forward_running_flag)
    else $error("reverse flag wrong during reverse drive");

  a_stop_flags: assert property (
    !drive.running |=> !flags.reverse_running_flag && !flags.forward_running_flag)
    else $error("rotation flag set while stopped");

  a_route_t11: assert property (
    ((sel_t11_q == `DSOF_CODE_45) && !cfg_q) |=> term.t11 == flags.heatsink_overheat_warning)
    else $error("terminal 11 not carrying selected flag");

  a_route_t12: assert property (
    (sel_t12_q == `DSOF_CODE_READY) |=> term.t12 == flags.drive_ready_flag)
    else $error("terminal 12 not carrying selected flag");

  a_cfg_prog2: assert property (
    ((sel_t12_q == `DSOF_CODE_45) && cfg_q) |=> term.t12 == flags.program_output[1])
    else $error("shared code not carrying program output 2");

  a_open_code: assert property (
    (sel_t12_q == 8'h00) |=> !term.t12)
    else $error("unknown option code closes the contact");

  a_route_relay: assert property (
    (sel_rly_q == `DSOF_CODE_FWD) |=> term.relay == flags.forward_running_flag)
    else $error("relay not a registered copy of chosen flag");

  a_irq_sticky: assert property (
    (stat_q[`DSOF_IRQ_OVH] && !wr_stat) |=> stat_q[`DSOF_IRQ_OVH])
    else $error("sticky status lost");

  a_stat_set_wins: assert property (
    ev[`DSOF_IRQ_OVH] |=> stat_q[`DSOF_IRQ_OVH])
    else $error("overheat event lost in status");

  a_reject_status: assert property (
    (op_cmd && !flags.drive_ready_flag) |=> stat_q[`DSOF_IRQ_REJECT])
    else $error("refused command not recorded");

  a_irq_level: assert property (
    ##1 irq == |($past(stat_q) & $past(mask_q)))
    else $error("interrupt does not follow masked status");

  a_rdata_idle: assert property (
    !$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data outside the read cycle");

  a_prog_on_write: assert property (
    wr_prog |=> ##1 flags.program_output == $past(wdata[2:0], 2))
    else $error("program output not taken from write");

  a_ready_fall: assert property (
    $fell(drive.can_accept) |=> !flags.drive_ready_flag)
    else $error("ready flag stays after drive stops accepting");

  c_cmd_taken:   cover property (op_cmd && flags.drive_ready_flag ##1 op_cmd_go);
  c_cmd_reject:  cover property (op_cmd && !flags.drive_ready_flag ##1 irq);
  c_dir_change:  cover property (flags.forward_running_flag ##[1:20] flags.reverse_running_flag);
  c_ovh_on_term: cover property ((sel_t11_q == `DSOF_CODE_45) && term.t11);
  c_cfg_prog2:   cover property (cfg_q && (sel_t12_q == `DSOF_CODE_45) ##1 term.t12);

endmodule

// option code decoder of one terminal; unknown codes leave the contact open
module dsof_opt_mux
  import dsof_pkg::*;
#(
  parameter int CODE_W = 8
)
(
  input  wire logic [CODE_W-1:0] code,
  input  wire dsof_flags_t       f,
  input  wire logic              c45_prog2,
  output var  logic              sel
);

  always_comb begin
    sel = 1'b0;
    case (code)
      `DSOF_CODE_LOWCUR: sel = f.low_current_indication;
      `DSOF_CODE_PROG1:  sel = f.program_output[0];
      `DSOF_CODE_45:     sel = c45_prog2 ? f.program_output[1] : f.heatsink_overheat_warning;
      `DSOF_CODE_PROG3:  sel = f.program_output[2];
      `DSOF_CODE_READY:  sel = f.drive_ready_flag;
      `DSOF_CODE_FWD:    sel = f.forward_running_flag;
      `DSOF_CODE_REV:    sel = f.reverse_running_flag;
      default:           sel = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// >>> dsof_load_model.sv
// relay and load model on the three output terminals
// assumed: terminals are registered on sys_clk, contact on = high
`timescale 1ns/10ps
`default_nettype none
module dsof_load_model
  import dsof_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire dsof_term_t term,
  output var  dsof_term_t contact_q
);
  // a relay follows its coil one cycle late; no bounce modelled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) contact_q <= '0;
    else     contact_q <= term;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench of the drive status flag block
// assumed: design and load model compiled before this file
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dsof_pkg::*;
  logic        sys_clk = 0;
  logic        rst = 1;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr_stb = 0;
  logic        rd_stb = 0;
  logic [31:0] rdata;
  dsof_meas_t  meas = '0;
  dsof_state_t drive = '0;
  logic        op_cmd = 0;
  logic        op_cmd_go;
  dsof_term_t  term;
  dsof_term_t  contact;
  dsof_flags_t flags;
  logic        irq;
  int          fails = 0;
  int          samples_checked = 0;
  logic [7:0]  codes [8] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h32, 8'h33, 8'h34, 8'h00};
  logic        exp_t [8] = '{1, 1, 0, 0, 1, 0, 1, 0};
  always #2.5 sys_clk = ~sys_clk;
  dsof_top dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .meas(meas), .drive(drive), .op_cmd(op_cmd), .op_cmd_go(op_cmd_go), .term(term),
    .flags(flags), .irq(irq));
  dsof_load_model load (.sys_clk(sys_clk), .rst(rst), .term(term), .contact_q(contact));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a; wdata <= d; wr_stb <= 1;
    @(posedge sys_clk);
    wr_stb <= 0;
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a; rd_stb <= 1;
    @(posedge sys_clk);
    rd_stb <= 0;
    #1 chk(n, e, rdata);
  endtask
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task cmd(input logic e);
    @(posedge sys_clk);
    op_cmd <= 1;
    @(posedge sys_clk);
    op_cmd <= 0;
    #1 chk("op_cmd_go", e, op_cmd_go);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    // all tests together take well under 2000 cycles
    #20000 fails++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    rd("sel_t11", 8'h0c, 32'h2d);
    rd("sel_t12", 8'h10, 32'h32);
    rd("sel_rly", 8'h14, 32'h33);
    rd("ovh_lvl", 8'h00, 32'hffff);
    rd("unmapped", 8'h40, 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'h0100);
    meas.temp <= 16'h0100;
    settle();
    chk("ovh at level", 0, flags.heatsink_overheat_warning);
    meas.temp <= 16'h0101;
    settle();
    chk("ovh above", 1, flags.heatsink_overheat_warning);
    chk("t11 ovh", 1, term.t11);
    chk("contact on", 1, contact.t11);
    chk("masked irq", 0, irq);
    rd("status", 8'h20, 32'h1);
    wr(8'h24, 32'h1);
    settle();
    chk("irq", 1, irq);
    meas.temp <= 16'h00ff;
    wr(8'h20, 32'h1);
    settle();
    chk("ovh below", 0, flags.heatsink_overheat_warning);
    chk("irq cleared", 0, irq);
    chk("contact", 0, contact.t11);
    $display("test overheat done");
    wr(8'h04, 32'h0050);
    wr(8'h10, 32'h2b);
    meas.current <= 16'h0050;
    settle();
    chk("lowcur at level", 0, flags.low_current_indication);
    meas.current <= 16'h004f;
    settle();
    chk("lowcur below", 1, flags.low_current_indication);
    chk("t12 lowcur", 1, term.t12);
    $display("test low current done");
    cmd(0);
    rd("status reject", 8'h20, 32'ha);
    drive <= '{running: 1'b0, reverse: 1'b0, can_accept: 1'b1};
    settle();
    chk("ready", 1, flags.drive_ready_flag);
    cmd(1);
    drive.can_accept <= 0;
    settle();
    chk("not ready", 0, flags.drive_ready_flag);
    cmd(0);
    $display("test ready done");
    for (int i = 0; i < 4; i++) begin
      drive <= '{running: i[1], reverse: i[0], can_accept: 1'b1};
      settle();
      chk("fwd flag", i == 2, flags.forward_running_flag);
      chk("rev flag", i == 3, flags.reverse_running_flag);
      chk("relay fwd", i == 2, term.relay);
    end
    $display("test direction done");
    wr(8'h08, 32'h3);
    settle();
    chk("prog", 3'b011, flags.program_output);
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, {24'h0, codes[i]});
      settle();
      chk("t12 code", exp_t[i], term.t12);
    end
    wr(8'h18, 32'h1);
    wr(8'h10, 32'h2d);
    settle();
    chk("code45 prog2", 1, term.t12);
    $display("test routing done");
    final_report();
  end
endmodule
`default_nettype wire
